//--- bkrcs_pkg.sv
package bkrcs_pkg;
  // ===========================================================================
  // Timing
  // ===========================================================================
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned SW_FREQ_MHZ = 1;
  localparam int unsigned SW_PERIOD_CYC = CLK_MHZ / SW_FREQ_MHZ;
  localparam int unsigned FOLD_DIV = 3;
  localparam int unsigned SCP_DIV = 8;
  localparam int unsigned PG_DELAY_US = 1000;
  localparam int unsigned PG_DELAY_CYC = PG_DELAY_US * CLK_MHZ;
  localparam int unsigned WAKE_DELAY_US = 600;
  localparam int unsigned WAKE_DELAY_CYC = WAKE_DELAY_US * CLK_MHZ;
  localparam int unsigned SOFT_START_US = 1100;
  localparam int unsigned SOFT_START_CYC = SOFT_START_US * CLK_MHZ;
  localparam int unsigned ZC_ENTRY_COUNT = 8;
  localparam logic [3:0] ZC_ENTRY = 4'h8;
  localparam logic [3:0] ZC_RESET = 4'h0;

  // ===========================================================================
  // Types
  // ===========================================================================
  typedef enum logic [2:0] {
    BKRCS_OFF = 3'b000,
    BKRCS_WAKE = 3'b001,
    BKRCS_SOFT = 3'b011,
    BKRCS_RUN = 3'b010,
    BKRCS_HALT = 3'b110
  } bkrcs_state_t;

  // Analog comparator flags, asynchronous active high
  typedef struct packed {
    logic current_trip;
    logic overcurrent;
    logic short_circuit;
    logic zero_cross;
    logic above_skip_high;
    logic below_nominal;
    logic below_skip_low;
    logic skip_peak;
    logic in_window;
    logic undervoltage;
    logic over_temp;
  } bkrcs_flags_t;

  // Switch drive outputs
  typedef struct packed {
    logic high_side;
    logic low_side;
    logic discharge;
  } bkrcs_drive_t;
endpackage

//--- bkrcs_sequencer.sv
// Operation
// - Mode low: forced fixed-frequency pulse-width, no skip after soft-start.
// - Mode high: pulse skipping allowed at light load.
// - Pulse-width cycles run at fixed one megahertz.
// - High side on at cycle start; trip swaps to low side until cycle end.
// - Eight consecutive zero-cross cycles enter skip mode.
// - Cycle without zero cross clears the counter.
// - Below eight, low side stays on through zero cross.
// - Skip pulse starts at clock edge; ends at +1.5% or peak limit.
// - After skip pulse low side on to zero cross, then both off, clock stopped; next pulse when output at nominal.
// - Output 1.5% below nominal leaves skip mode.
// - Overcurrent turns high side off until next cycle.
// - Feedback below 0.2V forces minimum oscillator frequency.
// - Power-good low until output regulated about one millisecond.
// - Reset input high forces power-good low; one millisecond after release.
// - Undervoltage lockout keeps regulator disabled, no switching.
// - Feedback below 0.2V at soft-start: clock at one third.
// - Soft-start always runs in skip mode.
// - Enable waits about 600 us before soft-start.
// - Enable low stops switching, turns on discharge.
// - Reset input falling restarts timer only if output in window.
// - Over-temperature shuts down; clearing resumes with fresh soft-start.
module bkrcs_sequencer (
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic enable_in,
  input wire logic mode_in,
  input wire logic good_flag_reset_input_in,
  input wire bkrcs_pkg::bkrcs_flags_t flags_in,
  output bkrcs_pkg::bkrcs_drive_t drive_out,
  output logic power_good_output_out,
  output logic skip_active_out
);
  // ===========================================================================
  // Input synchronisers
  // ===========================================================================
  bkrcs_pkg::bkrcs_flags_t meta_ff;
  bkrcs_pkg::bkrcs_flags_t flg_ff;
  logic [2:0] pin_meta_ff;
  logic [2:0] pin_ff;
  logic en_s, mode_s, rsi_s;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_ff <= '0;
      flg_ff <= '0;
      pin_meta_ff <= 3'h0;
      pin_ff <= 3'h0;
    end else begin
      meta_ff <= flags_in;
      flg_ff <= meta_ff;
      pin_meta_ff <= {enable_in, mode_in, good_flag_reset_input_in};
      pin_ff <= pin_meta_ff;
    end
  end
  assign en_s = pin_ff[2];
  assign mode_s = pin_ff[1];
  assign rsi_s = pin_ff[0];

  // ===========================================================================
  // Sequencer
  // ===========================================================================
  bkrcs_pkg::bkrcs_state_t state_ff;
  logic [17:0] seq_cnt_ff;
  logic slow_start_ff;

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= bkrcs_pkg::BKRCS_OFF;
      seq_cnt_ff <= 18'h0;
      slow_start_ff <= 1'b0;
    end else if (!en_s || flg_ff.undervoltage) begin
      state_ff <= bkrcs_pkg::BKRCS_OFF;
      seq_cnt_ff <= 18'h0;
    end else if (flg_ff.over_temp) begin
      state_ff <= bkrcs_pkg::BKRCS_HALT;
      seq_cnt_ff <= 18'h0;
    end else begin
      case (state_ff)
        bkrcs_pkg::BKRCS_OFF: begin
          state_ff <= bkrcs_pkg::BKRCS_WAKE;
          seq_cnt_ff <= 18'h0;
        end
        bkrcs_pkg::BKRCS_WAKE: begin
          if (seq_cnt_ff == 18'(bkrcs_pkg::WAKE_DELAY_CYC - 1)) begin
            state_ff <= bkrcs_pkg::BKRCS_SOFT;
            seq_cnt_ff <= 18'h0;
            slow_start_ff <= flg_ff.short_circuit;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 18'h1;
          end
        end
        bkrcs_pkg::BKRCS_SOFT: begin
          if (seq_cnt_ff == 18'(bkrcs_pkg::SOFT_START_CYC - 1)) begin
            state_ff <= bkrcs_pkg::BKRCS_RUN;
            slow_start_ff <= 1'b0;
          end else begin
            seq_cnt_ff <= seq_cnt_ff + 18'h1;
          end
        end
        bkrcs_pkg::BKRCS_RUN: state_ff <= bkrcs_pkg::BKRCS_RUN;
        default: begin
          state_ff <= bkrcs_pkg::BKRCS_SOFT;
          slow_start_ff <= flg_ff.short_circuit;
        end
      endcase
    end
  end

  logic active;
  assign active = (state_ff == bkrcs_pkg::BKRCS_SOFT) || (state_ff == bkrcs_pkg::BKRCS_RUN);

  // ===========================================================================
  // Oscillator
  // ===========================================================================
  logic [9:0] osc_cnt_ff;
  logic [9:0] period;
  logic tick;
  always_comb begin
    if (flg_ff.short_circuit && state_ff == bkrcs_pkg::BKRCS_RUN)
      period = 10'(bkrcs_pkg::SW_PERIOD_CYC * bkrcs_pkg::SCP_DIV);
    else if (flg_ff.short_circuit || slow_start_ff)
      period = 10'(bkrcs_pkg::SW_PERIOD_CYC * bkrcs_pkg::FOLD_DIV);
    else
      period = 10'(bkrcs_pkg::SW_PERIOD_CYC);
  end
  assign tick = active && (osc_cnt_ff >= period - 10'h1);
  logic skip_ff;
  logic idle_ff;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      osc_cnt_ff <= 10'h0;
    end else if (!active || (skip_ff && idle_ff && !flg_ff.below_nominal)) begin
      // clock stopped while idling in skip
      osc_cnt_ff <= 10'h0;
    end else if (tick) begin
      osc_cnt_ff <= 10'h0;
    end else begin
      osc_cnt_ff <= osc_cnt_ff + 10'h1;
    end
  end

  // ===========================================================================
  // Zero-cross counter and skip mode
  // ===========================================================================
  logic [3:0] zc_cnt_ff;
  logic zc_seen_ff;
  logic skip_allowed;
  assign skip_allowed = (state_ff == bkrcs_pkg::BKRCS_SOFT) || mode_s;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      zc_seen_ff <= 1'b0;
    end else if (tick) begin
      zc_seen_ff <= 1'b0;
    end else if (flg_ff.zero_cross) begin
      zc_seen_ff <= 1'b1;
    end
  end
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      zc_cnt_ff <= bkrcs_pkg::ZC_RESET;
    end else if (!skip_allowed || skip_ff || !active) begin
      zc_cnt_ff <= bkrcs_pkg::ZC_RESET;
    end else if (tick) begin
      if (!zc_seen_ff && !flg_ff.zero_cross)
        zc_cnt_ff <= bkrcs_pkg::ZC_RESET;
      else if (zc_cnt_ff != bkrcs_pkg::ZC_ENTRY)
        zc_cnt_ff <= zc_cnt_ff + 4'h1;
    end
  end
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      skip_ff <= 1'b0;
    end else if (!active || !skip_allowed) begin
      skip_ff <= (state_ff == bkrcs_pkg::BKRCS_SOFT);
    end else if (state_ff == bkrcs_pkg::BKRCS_SOFT) begin
      skip_ff <= 1'b1;
    end else if (skip_ff && flg_ff.below_skip_low) begin
      skip_ff <= 1'b0;
    end else if (zc_cnt_ff == bkrcs_pkg::ZC_ENTRY) begin
      skip_ff <= 1'b1;
    end
  end

  // ===========================================================================
  // Switch drive
  // ===========================================================================
  logic hs_ff, ls_ff, dis_ff, oc_lock_ff;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      oc_lock_ff <= 1'b0;
    end else if (flg_ff.overcurrent) begin
      oc_lock_ff <= 1'b1;
    end else if (tick) begin
      oc_lock_ff <= 1'b0;
    end
  end
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hs_ff <= 1'b0;
      ls_ff <= 1'b0;
      idle_ff <= 1'b0;
    end else if (!active) begin
      hs_ff <= 1'b0;
      ls_ff <= 1'b0;
      idle_ff <= 1'b0;
    end else if (flg_ff.overcurrent) begin
      hs_ff <= 1'b0;
      ls_ff <= !skip_ff;
    end else if (skip_ff) begin
      if (tick && !hs_ff && flg_ff.below_nominal) begin
        hs_ff <= 1'b1;
        ls_ff <= 1'b0;
        idle_ff <= 1'b0;
      end else if (hs_ff && (flg_ff.above_skip_high || flg_ff.skip_peak)) begin
        hs_ff <= 1'b0;
        ls_ff <= 1'b1;
      end else if (ls_ff && flg_ff.zero_cross) begin
        ls_ff <= 1'b0;
        idle_ff <= 1'b1;
      end
    end else if (tick) begin
      hs_ff <= 1'b1;
      ls_ff <= 1'b0;
      idle_ff <= 1'b0;
    end else if (hs_ff && flg_ff.current_trip) begin
      hs_ff <= 1'b0;
      ls_ff <= 1'b1;
    end
  end
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      dis_ff <= 1'b1;
    end else begin
      dis_ff <= !en_s || flg_ff.undervoltage;
    end
  end

  // ===========================================================================
  // Power-good timer
  // ===========================================================================
  logic [16:0] pg_cnt_ff;
  logic pg_ff;
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pg_cnt_ff <= 17'h0;
      pg_ff <= 1'b0;
    end else if (rsi_s || !flg_ff.in_window || state_ff != bkrcs_pkg::BKRCS_RUN) begin
      pg_cnt_ff <= 17'h0;
      pg_ff <= 1'b0;
    end else if (pg_cnt_ff == 17'(bkrcs_pkg::PG_DELAY_CYC - 1)) begin
      pg_ff <= 1'b1;
    end else begin
      pg_cnt_ff <= pg_cnt_ff + 17'h1;
    end
  end

  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      drive_out <= '0;
      power_good_output_out <= 1'b0;
      skip_active_out <= 1'b0;
    end else begin
      drive_out <= '{high_side: hs_ff, low_side: ls_ff, discharge: dis_ff};
      power_good_output_out <= pg_ff && !rsi_s;
      skip_active_out <= skip_ff;
    end
  end

  // ===========================================================================
  // Checks
  // ===========================================================================
  a_forced_no_skip: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    (state_ff == bkrcs_pkg::BKRCS_RUN && !mode_s) |=> !skip_ff)
    else $error("skip entered in forced mode");
  a_zc_clear: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    (tick && !zc_seen_ff && !flg_ff.zero_cross) |=> zc_cnt_ff == 4'h0)
    else $error("zero-cross count not cleared");
  a_oc_off: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    flg_ff.overcurrent |=> !hs_ff)
    else $error("high side on during overcurrent");
  a_fault_noswitch: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    flg_ff.undervoltage |=> ##1 !hs_ff && !ls_ff)
    else $error("switching under lockout");
  a_soft_skip: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    (state_ff == bkrcs_pkg::BKRCS_SOFT && $past(state_ff) == bkrcs_pkg::BKRCS_SOFT) |-> skip_ff)
    else $error("soft-start not in skip");
  a_rsi_pg_low: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    rsi_s |=> !power_good_output_out)
    else $error("power-good high during reset input");
  a_temp_halt: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    (flg_ff.over_temp && en_s && !flg_ff.undervoltage) |=> state_ff == bkrcs_pkg::BKRCS_HALT)
    else $error("no shutdown on over-temperature");
  a_disable_dis: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    !en_s |=> ##1 drive_out.discharge)
    else $error("no discharge when disabled");
  sequence bkrcs_skip_cut_s;
    skip_ff && hs_ff && (flg_ff.above_skip_high || flg_ff.skip_peak);
  endsequence
  a_skip_cut: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    bkrcs_skip_cut_s |=> !hs_ff)
    else $error("skip pulse not ended");
  a_oc_lock_hold: assert property (
    @(posedge mclk_in) disable iff (!reset_n_in)
    (oc_lock_ff && !tick) |=> !hs_ff)
    else $error("high side on before next cycle");
endmodule

//--- bkrcs_far_side.sv
// ============================================================
// Comparator model driven by the switch states
// ============================================================
module bkrcs_far_side (
  input wire logic mclk_in,
  input wire bkrcs_pkg::bkrcs_drive_t drive_in,
  input wire logic uv_in,
  input wire logic ot_in,
  input wire logic oc_in,
  input wire logic sc_in,
  output bkrcs_pkg::bkrcs_flags_t flags_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] on_ff = 8'h00;
  logic [7:0] off_ff = 8'h00;
  logic [7:0] low_ff = 8'h00;

  // Inductor current and output level follow how long each switch conducts
  always_ff @(posedge mclk_in) begin
    on_ff <= !drive_in.high_side ? 8'h00 : (on_ff == 8'hff) ? on_ff : on_ff + 8'h01;
    off_ff <= drive_in.high_side ? 8'h00 : (off_ff == 8'hff) ? off_ff : off_ff + 8'h01;
    low_ff <= !drive_in.low_side ? 8'h00 : (low_ff == 8'hff) ? low_ff : low_ff + 8'h01;
  end

  always_comb begin
    flags_out = '0;
    flags_out.current_trip = (on_ff >= 8'h0a);
    flags_out.above_skip_high = (on_ff >= 8'h08);
    flags_out.overcurrent = oc_in;
    flags_out.short_circuit = sc_in;
    flags_out.zero_cross = (low_ff >= 8'h14);
    flags_out.below_nominal = (off_ff >= 8'h3c);
    flags_out.undervoltage = uv_in;
    flags_out.over_temp = ot_in;
  end
endmodule

//--- testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic enable_in = 1'b0;
  logic mode_in = 1'b0;
  logic good_flag_reset_input_in = 1'b0;
  logic uv = 1'b1;
  logic ot = 1'b0;
  logic oc = 1'b0;
  logic sc = 1'b0;
  bkrcs_pkg::bkrcs_flags_t flags_in;
  bkrcs_pkg::bkrcs_drive_t drive_out;
  logic power_good_output_out;
  logic skip_active_out;
  int err_count = 0;
  int n_tests = 0;
  int hs_cnt = 0;
  int n;
  int snap;

  always #4 mclk_in = ~mclk_in;

  // ============================================================
  // Design and far side
  // ============================================================
  bkrcs_sequencer DUT (
    .mclk_in(mclk_in),
    .reset_n_in(reset_n_in),
    .enable_in(enable_in),
    .mode_in(mode_in),
    .good_flag_reset_input_in(good_flag_reset_input_in),
    .flags_in(flags_in),
    .drive_out(drive_out),
    .power_good_output_out(power_good_output_out),
    .skip_active_out(skip_active_out)
  );

  bkrcs_far_side far (
    .mclk_in(mclk_in),
    .drive_in(drive_out),
    .uv_in(uv),
    .ot_in(ot),
    .oc_in(oc),
    .sc_in(sc),
    .flags_out(flags_in)
  );

  // Counts cycles with the high side conducting
  always @(posedge mclk_in) begin
    if (drive_out.high_side === 1'b1) hs_cnt <= hs_cnt + 1;
  end

  // ============================================================
  // Tasks
  // ============================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge mclk_in);
  endtask

  task automatic wait_hs(input logic lvl, input int max, output int cnt);
    cnt = 0;
    @(negedge mclk_in);
    while (drive_out.high_side !== lvl && cnt < max) begin
      @(negedge mclk_in);
      cnt++;
    end
  endtask

  task automatic tally_and_finish;
    $display("errors=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    #800000;
    err_count++;
    tally_and_finish;
  end

  // ============================================================
  // Tests
  // ============================================================
  initial begin
    // Reset input held low so power-good tracks the output
    cyc(2);
    @(negedge mclk_in);
    chk({drive_out, power_good_output_out, skip_active_out}, 32'h0);
    cyc(1);
    reset_n_in <= 1'b1;
    cyc(6);
    @(negedge mclk_in);
    chk(drive_out, 32'h1);
    cyc(1);
    enable_in <= 1'b1;
    cyc(2000);
    chk(hs_cnt, 32'h0);
    enable_in <= 1'b0;
    uv <= 1'b0;
    cyc(10);
    enable_in <= 1'b1;
    cyc(74000);
    chk(hs_cnt, 32'h0);
    @(negedge mclk_in);
    chk(skip_active_out, 32'h0);
    n = 0;
    while (skip_active_out !== 1'b1 && n < 2000) begin
      @(negedge mclk_in);
      n++;
    end
    chk(skip_active_out, 32'h1);
    wait_hs(1'b1, 2 * bkrcs_pkg::SW_PERIOD_CYC + 200, n);
    chk(drive_out.high_side, 32'h1);
    wait_hs(1'b0, 30, n);
    chk(n >= 8 && n <= 16, 32'h1);
    cyc(40);
    @(negedge mclk_in);
    chk(drive_out[2:1], 32'h0);
    wait_hs(1'b1, 300, n);
    chk(n < 300, 32'h1);
    cyc(1);
    oc <= 1'b1;
    wait_hs(1'b0, 10, n);
    chk(n <= 6, 32'h1);
    cyc(2);
    oc <= 1'b0;
    wait_hs(1'b0, 300, n);
    cyc(1);
    ot <= 1'b1;
    cyc(6);
    snap = hs_cnt;
    @(negedge mclk_in);
    chk(drive_out[2:1], 32'h0);
    cyc(200);
    chk(hs_cnt - snap, 32'h0);
    ot <= 1'b0;
    sc <= 1'b1;
    wait_hs(1'b1, 3000, n);
    chk(n < 3000, 32'h1);
    chk(n > 2 * bkrcs_pkg::SW_PERIOD_CYC, 32'h1);
    chk(skip_active_out, 32'h1);
    chk(power_good_output_out, 32'h0);
    tally_and_finish;
  end
endmodule
